// *** rtl/dif_pkg.sv ***
`default_nettype none
// ****************************************************************
// Shared constants for the input function decoder
// ****************************************************************
package dif_pkg;
  // Terminal bit positions in the synchronised vector
  localparam int TERM_W    = 20;
  localparam int T_FWD     = 0;
  localparam int T_REV     = 1;
  localparam int T_SPD0    = 2;   // Four speed bits sit at T_SPD0..T_SPD0+3
  localparam int T_JOG     = 6;
  localparam int T_BRAKE   = 7;
  localparam int T_MOTOR2  = 8;
  localparam int T_RAMP2   = 9;
  localparam int T_COAST   = 10;
  localparam int T_FAULT   = 11;
  localparam int T_USP     = 12;
  localparam int T_BYPASS  = 13;
  localparam int T_LOCK    = 14;
  localparam int T_CLEAR   = 15;
  localparam int T_GO      = 16;
  localparam int T_HALT    = 17;
  localparam int T_DIR     = 18;
  localparam int T_PIDHOLD = 19;
  // Integrator clear shares no slot; it is passed through the same stages
  localparam int SPD_W     = 4;
  // Trip code shown for an external trip
  localparam logic [7:0] TRIP_CODE_EXT  = 8'h0C;
  localparam logic [7:0] TRIP_CODE_NONE = 8'h00;
  // Trip history counter width and saturation value
  localparam logic [3:0] HIST_MAX = 4'hF;
  localparam logic [3:0] HIST_RST = 4'h0;
  // Cycles after reset before the synchronised terminals are trusted
  localparam logic [1:0] SETTLE_CYC = 2'h2;
  // Power-up sequencing
  typedef enum logic [1:0] {
    DIF_PU_SETTLE  = 2'b00,
    DIF_PU_INHIBIT = 2'b01,
    DIF_PU_RUN     = 2'b10
  } dif_pu_t;
endpackage : dif_pkg
`default_nettype wire

// *** rtl/dif_sync_if.sv ***
`default_nettype none
// ****************************************************************
// Raw and synchronised terminal levels between decoder and stages
// ****************************************************************
interface dif_sync_if;
  logic [dif_pkg::TERM_W:0] raw;   // Pin levels, top bit is integrator clear
  logic [dif_pkg::TERM_W:0] sync;  // Same levels after two flip-flops
  modport dec (output raw, input sync);
  modport syn (input raw, output sync);
endinterface : dif_sync_if
`default_nettype wire

// *** rtl/dif_sync.sv ***
`default_nettype none
// ****************************************************************
// Two flip-flop synchroniser for every terminal
// ****************************************************************
module dif_sync (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  dif_sync_if.syn   term
);
  import dif_pkg::*;

  logic [TERM_W:0] meta;  // First stage, read only by the second

  // ****************************************************************
  // Stages
  // ****************************************************************
  // Both stages freeze with the clock enable like all other state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta      <= '0;
      term.sync <= '0;
    end else if (clk_en) begin
      meta      <= term.raw;
      term.sync <= meta;
    end
  end
endmodule : dif_sync
`default_nettype wire

// *** rtl/dif_decoder.sv ***
// Contract
// - Forward input runs motor forward, else stop
// - Reverse input runs motor reverse, else stop
// - Four speed bits form binary preset index
// - Jog input runs at jog frequency
// - Brake input enables DC braking on deceleration
// - Second motor input selects second parameter set
// - Ramp input selects second-stage accel/decel
// - Coast input turns motor output off
// - Rising external fault latches trip code twelve
// - Latched trip stays until reset
// - Blocking input at power-up prevents run resume
// - Bypass input hands motor to line power
// - Lock input rejects parameter edits
// - Reset clears trip, output off, reset asserted
// - Three-wire start begins, stop ends rotation
// - Three-wire stop wins regardless of start
// - Direction change decelerates first, then reverses
// - PID hold input suspends PID loop
// - Integrator clear resets PID sum
`default_nettype none
module dif_decoder (
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  // Terminal inputs, asynchronous
  input  wire logic               run_forward_in,
  input  wire logic               run_reverse_in,
  input  wire logic               speed_sel_bit0,
  input  wire logic               speed_sel_bit1,
  input  wire logic               speed_sel_bit2,
  input  wire logic               speed_sel_bit3,
  input  wire logic               jog_in,
  input  wire logic               dc_brake_in,
  input  wire logic               motor2_sel_in,
  input  wire logic               second_ramp_sel,
  input  wire logic               coast_stop_in,
  input  wire logic               external_fault_in,
  input  wire logic               unattended_start_block,
  input  wire logic               line_bypass_in,
  input  wire logic               param_lock_in,
  input  wire logic               fault_clear_in,
  input  wire logic               three_wire_go,
  input  wire logic               three_wire_halt,
  input  wire logic               three_wire_dir_in,
  input  wire logic               pid_hold_in,
  input  wire logic               loop_integrator_clear,
  // Configuration and drive feedback, same clock
  input  wire logic               three_wire_mode,
  input  wire logic               pid_enable,
  input  wire logic               saved_run,
  input  wire logic               saved_dir_fwd,
  input  wire logic               motor_stopped,
  input  wire logic               edit_req,
  // Decoded actions
  output logic                    run_cmd,
  output logic                    dir_fwd,
  output logic                    decel_req,
  output logic [dif_pkg::SPD_W-1:0] speed_index,
  output logic                    jog_active,
  output logic                    dc_brake_en,
  output logic                    motor2_active,
  output logic                    ramp2_active,
  output logic                    output_off,
  output logic                    bypass_active,
  output logic                    trip_latched,
  output logic [7:0]              trip_code,
  output logic [3:0]              trip_history,
  output logic                    edit_accept,
  output logic                    reset_req,
  output logic                    pid_suspend,
  output logic                    pid_int_clear
);
  import dif_pkg::*;

  // ****************************************************************
  // Synchronisation
  // ****************************************************************
  dif_sync_if term ();             // Carrier to the synchroniser

  logic [TERM_W:0] t;              // Synchronised terminal levels
  logic            fault_prev;     // Last synchronised fault level

  assign term.raw = {loop_integrator_clear, pid_hold_in, three_wire_dir_in,
                     three_wire_halt, three_wire_go, fault_clear_in,
                     param_lock_in, line_bypass_in, unattended_start_block,
                     external_fault_in, coast_stop_in, second_ramp_sel,
                     motor2_sel_in, dc_brake_in, jog_in, speed_sel_bit3,
                     speed_sel_bit2, speed_sel_bit1, speed_sel_bit0,
                     run_reverse_in, run_forward_in};
  assign t = term.sync;

  dif_sync u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .term    (term)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Two-wire direction request; both or neither yields no run
  function automatic logic two_wire_run(input logic fwd, input logic rev);
    return fwd ^ rev;
  endfunction : two_wire_run

  // ****************************************************************
  // Power-up sequencing
  // ****************************************************************
  dif_pu_t    pu_state;            // Power-up phase
  logic [1:0] settle_cnt;          // Waits out the synchroniser
  logic       want_run;            // Requested run before gating
  logic       want_fwd;            // Requested direction

  // Terminals need two edges to reach t; only then is the block level valid
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pu_state   <= DIF_PU_SETTLE;
      settle_cnt <= 2'h0;
    end else if (clk_en) begin
      unique case (pu_state)
        DIF_PU_SETTLE: begin
          if (settle_cnt == SETTLE_CYC) begin
            // Blocking level sampled once, after release
            pu_state <= t[T_USP] ? DIF_PU_INHIBIT : DIF_PU_RUN;
          end else begin
            settle_cnt <= settle_cnt + 2'h1;
          end
        end
        DIF_PU_INHIBIT: begin
          // Held run is dropped; a fresh command needs the run request want_run to go low first
          if (!want_run) begin
            pu_state <= DIF_PU_RUN;
          end
        end
        DIF_PU_RUN: begin
          pu_state <= DIF_PU_RUN;
        end
        default: pu_state <= DIF_PU_SETTLE;  // Spare code recovers
      endcase
    end
  end

  // ****************************************************************
  // Three-wire run latch
  // ****************************************************************
  logic tw_run;                    // Latched three-wire run state
  logic tw_loaded;                 // Saved run already applied

  // Halt or clear beats go; with none active only the one-time saved-run load changes the state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tw_run    <= 1'b0;
      tw_loaded <= 1'b0;
    end else if (clk_en) begin
      if (t[T_HALT] || t[T_CLEAR]) begin
        tw_run <= 1'b0;
      end else if (t[T_GO]) begin
        tw_run <= 1'b1;
      end else if (pu_state == DIF_PU_SETTLE && settle_cnt == SETTLE_CYC
                   && !tw_loaded) begin
        // Resume the run held before power loss unless blocked
        tw_run    <= saved_run && !t[T_USP];
        tw_loaded <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Run request decode
  // ****************************************************************
  always_comb begin
    if (three_wire_mode) begin
      want_run = tw_run;
      want_fwd = t[T_DIR];
    end else if (two_wire_run(t[T_FWD], t[T_REV])) begin
      want_run = 1'b1;
      want_fwd = t[T_FWD];
    end else begin
      // Jog alone runs; forward plus reverse is a stop
      want_run = t[T_JOG] && !(t[T_FWD] && t[T_REV]);
      want_fwd = dir_fwd;
    end
  end

  // ****************************************************************
  // Direction hold for reversal
  // ****************************************************************
  logic applied_fwd;               // Direction actually driven
  logic dir_change;                // Request differs from driven

  assign dir_change = want_run && (want_fwd != applied_fwd);

  // Reversal waits for the motor to stop so it never plugs the drive
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      applied_fwd <= 1'b1;
    end else if (clk_en) begin
      if (pu_state == DIF_PU_SETTLE && three_wire_mode) begin
        applied_fwd <= saved_dir_fwd;
      end else if (dir_change && motor_stopped) begin
        applied_fwd <= want_fwd;
      end
    end
  end

  // ****************************************************************
  // External trip latch
  // ****************************************************************
  logic fault_rise;                // Off-to-on transition of fault input

  assign fault_rise = t[T_FAULT] && !fault_prev;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_prev <= 1'b0;
    end else if (clk_en) begin
      fault_prev <= t[T_FAULT];
    end
  end

  // A new trip in the clearing cycle survives: set beats clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trip_latched <= 1'b0;
      trip_code    <= TRIP_CODE_NONE;
    end else if (clk_en) begin
      if (fault_rise) begin
        trip_latched <= 1'b1;
        trip_code    <= TRIP_CODE_EXT;
      end else if (t[T_CLEAR]) begin
        trip_latched <= 1'b0;
        trip_code    <= TRIP_CODE_NONE;
      end
    end
  end

  // History counts trips; falling fault never touches it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trip_history <= HIST_RST;
    end else if (clk_en) begin
      if (fault_rise && trip_history != HIST_MAX) begin
        trip_history <= trip_history + 4'h1;
      end else if (t[T_CLEAR] && !fault_rise) begin
        trip_history <= HIST_RST;
      end
    end
  end

  // ****************************************************************
  // Motion outputs
  // ****************************************************************
  logic stop_force;                // Any reason the output must be off
  logic run_ok;                    // Run allowed this cycle

  assign stop_force = t[T_COAST] || t[T_CLEAR] || trip_latched
                      || t[T_BYPASS];
  assign run_ok     = want_run && (pu_state == DIF_PU_RUN) && !stop_force;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_cmd    <= 1'b0;
      dir_fwd    <= 1'b1;
      decel_req  <= 1'b0;
      jog_active <= 1'b0;
      output_off <= 1'b1;
    end else if (clk_en) begin
      // Reversal: run drops and decel_req is raised while the drive ramps down
      run_cmd    <= run_ok && !dir_change;
      dir_fwd    <= applied_fwd;
      decel_req  <= run_ok && dir_change && !motor_stopped;
      jog_active <= run_ok && !three_wire_mode && t[T_JOG]
                    && !two_wire_run(t[T_FWD], t[T_REV]);
      output_off <= stop_force;
    end
  end

  // ****************************************************************
  // Selection outputs
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      speed_index   <= '0;
      dc_brake_en   <= 1'b0;
      motor2_active <= 1'b0;
      ramp2_active  <= 1'b0;
      bypass_active <= 1'b0;
    end else if (clk_en) begin
      speed_index   <= t[T_SPD0 +: SPD_W];
      dc_brake_en   <= t[T_BRAKE];
      motor2_active <= t[T_MOTOR2];
      ramp2_active  <= t[T_RAMP2];
      bypass_active <= t[T_BYPASS];
    end
  end

  // ****************************************************************
  // Lock, reset and PID outputs
  // ****************************************************************
  // Edit request comes from same-clock logic; lock is a synced pin
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      edit_accept   <= 1'b0;
      reset_req     <= 1'b0;
      pid_suspend   <= 1'b0;
      pid_int_clear <= 1'b0;
    end else if (clk_en) begin
      edit_accept   <= edit_req && !t[T_LOCK];
      reset_req     <= t[T_CLEAR];
      pid_suspend   <= pid_enable && t[T_PIDHOLD];
      pid_int_clear <= t[TERM_W];
    end
  end
endmodule : dif_decoder
`default_nettype wire

// *** bench/dif_switch_model.sv ***
`default_nettype none
// ****************************************************************
// Terminal switch bank on the far side of the decoder
// ****************************************************************
module dif_switch_model (
  input  wire logic                    ref_clk,
  input  wire logic [dif_pkg::TERM_W:0] want,
  output var  logic [dif_pkg::TERM_W:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import dif_pkg::*;
  // Contacts open before the first edge, then move on falling edges only
  // One process owns the pins, so they never have two drivers
  initial begin
    pins = '0;
    forever begin
      @(negedge ref_clk);
      pins <= want;
    end
  end
endmodule : dif_switch_model
`default_nettype wire

// *** bench/dif_decoder_asserts.sv ***
`default_nettype none
// ****************************************************************
// Port relations of the input decoder
// ****************************************************************
module dif_decoder_asserts (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       run_forward_in,
  input wire logic       run_reverse_in,
  input wire logic       speed_sel_bit0,
  input wire logic       speed_sel_bit1,
  input wire logic       speed_sel_bit2,
  input wire logic       speed_sel_bit3,
  input wire logic       dc_brake_in,
  input wire logic       coast_stop_in,
  input wire logic       external_fault_in,
  input wire logic       param_lock_in,
  input wire logic       fault_clear_in,
  input wire logic       three_wire_halt,
  input wire logic       three_wire_mode,
  input wire logic       edit_req,
  input wire logic       run_cmd,
  input wire logic [3:0] speed_index,
  input wire logic       dc_brake_en,
  input wire logic       output_off,
  input wire logic       trip_latched,
  input wire logic [7:0] trip_code,
  input wire logic       edit_accept,
  input wire logic       reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up;  // Edges since reset, saturating
  logic       ok;  // Pipeline history valid
  // $past reaches three edges back (four for halt), so wait three edges after reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  assign ok = (up == 2'h3);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  speed_map_a: assert property (
    ok |-> speed_index == $past({speed_sel_bit3, speed_sel_bit2, speed_sel_bit1,
                                 speed_sel_bit0}, 3))
    else $error("speed index wrong");
  brake_follow_a: assert property (
    ok |-> dc_brake_en == $past(dc_brake_in, 3))
    else $error("brake enable wrong");
  trip_set_a: assert property (
    ok && $rose(external_fault_in) |-> ##3 (trip_latched && trip_code == 8'h0C))
    else $error("trip not latched");
  trip_hold_a: assert property (
    ok && $fell(trip_latched) |-> $past(fault_clear_in, 3))
    else $error("trip dropped without clear");
  coast_off_a: assert property (
    ok && $past(coast_stop_in, 3) |-> output_off && !run_cmd)
    else $error("coast did not cut output");
  clear_off_a: assert property (
    ok && $past(fault_clear_in, 3) |-> output_off && reset_req)
    else $error("clear did not reset");
  edit_gate_a: assert property (
    ok |-> edit_accept == ($past(edit_req) && !$past(param_lock_in, 3)))
    else $error("edit gate wrong");
  both_dirs_a: assert property (
    ok && !three_wire_mode && !$past(three_wire_mode)
    && $past(run_forward_in && run_reverse_in, 3) |-> !run_cmd)
    else $error("both directions ran");
  // Halt passes the run latch as well, so it needs one edge more
  halt_stop_a: assert property (
    ok && three_wire_mode && $past(three_wire_mode)
    && $past(three_wire_halt, 4) |-> !run_cmd)
    else $error("halt did not stop");
  cover property (ok && trip_latched && fault_clear_in);
  cover property (ok && run_cmd && three_wire_mode);
  cover property (ok && edit_req && param_lock_in);
endmodule : dif_decoder_asserts
bind dif_decoder dif_decoder_asserts chk (
  .ref_clk, .sys_rst, .run_forward_in, .run_reverse_in, .speed_sel_bit0,
  .speed_sel_bit1, .speed_sel_bit2, .speed_sel_bit3, .dc_brake_in, .coast_stop_in,
  .external_fault_in, .param_lock_in, .fault_clear_in, .three_wire_halt,
  .three_wire_mode, .edit_req, .run_cmd, .speed_index, .dc_brake_en, .output_off,
  .trip_latched, .trip_code, .edit_accept, .reset_req
);
`default_nettype wire

// *** bench/tb_top.sv ***
`default_nettype none
// ****************************************************************
// Self-checking bench for the input decoder
// ****************************************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dif_pkg::*;
  // Same-clock configuration and feedback inputs
  typedef struct packed {logic mode3, pid_en, srun, sdir, stopped, edit;} dif_cfg_t;
  logic              ref_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [TERM_W:0]   want    = '0;  // Requested contact levels
  logic [TERM_W:0]   pins;          // Levels at the terminals
  dif_cfg_t          cfg     = '0;
  logic [31:0]       seed    = 32'h8F03;
  logic [3:0]        speed_index, trip_history;
  logic [7:0]        trip_code;
  logic run_cmd, dir_fwd, decel_req, jog_active, dc_brake_en, motor2_active;
  logic ramp2_active, output_off, bypass_active, trip_latched, edit_accept;
  logic reset_req, pid_suspend, pid_int_clear;
  int                fail_count   = 0;
  int                total_checks = 0;
  dif_switch_model sw (.ref_clk, .want, .pins);
  dif_decoder DUT (
    .ref_clk, .sys_rst, .clk_en(1'b1),
    .run_forward_in(pins[T_FWD]), .run_reverse_in(pins[T_REV]),
    .speed_sel_bit0(pins[T_SPD0]), .speed_sel_bit1(pins[T_SPD0+1]),
    .speed_sel_bit2(pins[T_SPD0+2]), .speed_sel_bit3(pins[T_SPD0+3]),
    .jog_in(pins[T_JOG]), .dc_brake_in(pins[T_BRAKE]), .motor2_sel_in(pins[T_MOTOR2]),
    .second_ramp_sel(pins[T_RAMP2]), .coast_stop_in(pins[T_COAST]),
    .external_fault_in(pins[T_FAULT]), .unattended_start_block(pins[T_USP]),
    .line_bypass_in(pins[T_BYPASS]), .param_lock_in(pins[T_LOCK]),
    .fault_clear_in(pins[T_CLEAR]), .three_wire_go(pins[T_GO]),
    .three_wire_halt(pins[T_HALT]), .three_wire_dir_in(pins[T_DIR]),
    .pid_hold_in(pins[T_PIDHOLD]), .loop_integrator_clear(pins[TERM_W]),
    .three_wire_mode(cfg.mode3), .pid_enable(cfg.pid_en), .saved_run(cfg.srun),
    .saved_dir_fwd(cfg.sdir), .motor_stopped(cfg.stopped), .edit_req(cfg.edit),
    .run_cmd, .dir_fwd, .decel_req, .speed_index, .jog_active, .dc_brake_en,
    .motor2_active, .ramp2_active, .output_off, .bypass_active, .trip_latched,
    .trip_code, .trip_history, .edit_accept, .reset_req, .pid_suspend, .pid_int_clear
  );
  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Pseudo-random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // Any cutting condition forces the drive output off
  function automatic logic exp_off(input logic coast, clr, trip, bypass);
    return coast | clr | trip | bypass;
  endfunction : exp_off
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // Model lag plus three pipeline edges, with margin
  task automatic put(input int idx, input logic v);
    @(negedge ref_clk);
    want[idx] <= v;
    repeat (5) @(negedge ref_clk);
  endtask : put
  task automatic do_reset();
    @(negedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst <= 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask : do_reset
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
  initial begin
    cfg.stopped = 1'b1;
    do_reset();
    // Two-wire run, reversal, clash, jog, coast
    put(T_FWD, 1'b1); check(run_cmd, 1); check(dir_fwd, 1);
    put(T_FWD, 1'b0); check(run_cmd, 0);
    put(T_REV, 1'b1); check(run_cmd, 1); check(dir_fwd, 0);
    put(T_FWD, 1'b1); check(run_cmd, 0);
    put(T_FWD, 1'b0); put(T_REV, 1'b0); check(run_cmd, 0);
    put(T_JOG, 1'b1); check(run_cmd, 1); check(jog_active, 1);
    put(T_JOG, 1'b0); check(run_cmd, 0); check(jog_active, 0);
    put(T_FWD, 1'b1); put(T_COAST, 1'b1);
    check(output_off, exp_off(1, 0, 0, 0)); check(run_cmd, 0);
    put(T_COAST, 1'b0); check(output_off, 0); check(run_cmd, 1);
    put(T_FWD, 1'b0);
    // Random levels on the plain pass-through functions
    for (int i = 0; i < 24; i++) begin
      seed = lfsr_next(seed);
      @(negedge ref_clk);
      want[T_SPD0 +: 4] <= seed[3:0];
      want[T_BRAKE]     <= seed[4];
      want[T_MOTOR2]    <= seed[5];
      want[T_RAMP2]     <= seed[6];
      want[T_BYPASS]    <= seed[7];
      want[T_PIDHOLD]   <= seed[8];
      want[TERM_W]      <= seed[9];
      cfg.pid_en        <= seed[10];
      repeat (5) @(negedge ref_clk);
      check(speed_index, seed[3:0]);
      check(dc_brake_en, seed[4]);
      check(motor2_active, seed[5]);
      check(ramp2_active, seed[6]);
      check(bypass_active, seed[7]);
      check(output_off, exp_off(0, 0, 0, seed[7]));
      check(pid_suspend, seed[8] & seed[10]);
      check(pid_int_clear, seed[9]);
    end
    @(negedge ref_clk);
    want <= '0;
    // External trip, hold, second rise, clear
    put(T_FAULT, 1'b1); check(trip_latched, 1); check(trip_code, 8'h0C);
    check(trip_history, 1);
    put(T_FAULT, 1'b0); check(trip_latched, 1); check(trip_code, 8'h0C);
    put(T_FAULT, 1'b1); check(trip_history, 2);
    put(T_CLEAR, 1'b1); check(trip_latched, 0); check(reset_req, 1);
    check(output_off, 1);
    put(T_CLEAR, 1'b0); put(T_FAULT, 1'b0); check(trip_latched, 0);
    check(trip_code, 8'h00); check(reset_req, 0);
    // Three-wire start, stop, direction change
    cfg.mode3 <= 1'b1;
    put(T_DIR, 1'b1); put(T_GO, 1'b1); put(T_GO, 1'b0);
    check(run_cmd, 1); check(dir_fwd, 1);
    put(T_HALT, 1'b1); check(run_cmd, 0);
    put(T_GO, 1'b1); check(run_cmd, 0);
    put(T_HALT, 1'b0); check(run_cmd, 1);
    put(T_GO, 1'b0); check(run_cmd, 1);
    cfg.stopped <= 1'b0;
    put(T_DIR, 1'b0); check(run_cmd, 0); check(decel_req, 1); check(dir_fwd, 1);
    cfg.stopped <= 1'b1;
    repeat (5) @(negedge ref_clk);
    check(dir_fwd, 0); check(run_cmd, 1); check(decel_req, 0);
    // Power-up resume with and without the start block
    put(T_DIR, 1'b1); cfg.srun <= 1'b1; cfg.sdir <= 1'b0;
    put(T_USP, 1'b1); do_reset(); check(run_cmd, 0); check(dir_fwd, 0);
    cfg.sdir <= 1'b1;
    put(T_USP, 1'b0); do_reset(); check(run_cmd, 1); check(dir_fwd, 1);
    // Edit requests under and without the lock
    put(T_LOCK, 1'b1); cfg.edit <= 1'b1;
    repeat (2) @(negedge ref_clk);
    check(edit_accept, 0);
    put(T_LOCK, 1'b0); check(edit_accept, 1);
    // Two-wire run held through power-up stays off until released
    cfg.mode3 <= 1'b0; put(T_USP, 1'b1); put(T_FWD, 1'b1);
    do_reset(); check(run_cmd, 0);
    put(T_FWD, 1'b0); put(T_FWD, 1'b1); check(run_cmd, 1);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
